// ==== msl_top.sv ====
// modem state lock register bank on ahb-lite with force outputs
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module msl_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // modem state machine
    input  wire msl_pkg::msl_mstate_t modem_state_live,
    output var  msl_pkg::msl_force_t  modem_force
);
    localparam logic [31:0] ADDR_MD = {msl_pkg::ADDR_TOP,
        msl_pkg::IDX_MODEM_CTRL, msl_pkg::ADDR_PAD};
    localparam logic [31:0] ADDR_TX = {msl_pkg::ADDR_TOP,
        msl_pkg::IDX_TX_CTRL, msl_pkg::ADDR_PAD};

    msl_pkg::msl_regs_t st_r;
    msl_pkg::msl_regs_t st_nxt;

    logic                        access;
    logic                        hit_md;
    logic                        hit_tx;
    msl_pkg::msl_ctrl_t          ctrl_new;
    logic [7:0]                  md_read;
    logic [7:0]                  tx_read;

    // a transfer is taken only when the previous one has finished
    assign access = hsel & hready & (htrans == msl_pkg::HTRANS_NONSEQ |
                                     htrans == msl_pkg::HTRANS_SEQ);
    assign hit_md = haddr == ADDR_MD;
    assign hit_tx = haddr == ADDR_TX;

    always_comb begin
        ctrl_new = st_r.ctrl;
        // data phase of a write: update bits from hwdata
        if (st_r.wr_md) begin
            ctrl_new.tx_state_lock    = hwdata[msl_pkg::BIT_TX_LOCK];
            ctrl_new.modem_state_lock = hwdata[msl_pkg::BIT_MD_LOCK];
            // the write lands in the recorded copy only, never the live state
            ctrl_new.modem_state_rec  =
                hwdata[msl_pkg::MD_VAL_LSB +: msl_pkg::MD_VAL_W];
        end
        if (st_r.wr_tx) begin
            ctrl_new.tx_state_value =
                hwdata[msl_pkg::TX_VAL_LSB +: msl_pkg::TX_VAL_W];
            ctrl_new.modem_state_update = hwdata[msl_pkg::BIT_MD_UPD];
        end
    end

    always_comb begin
        md_read = 8'h00;
        md_read[msl_pkg::BIT_TX_LOCK] = ctrl_new.tx_state_lock;
        md_read[msl_pkg::BIT_MD_LOCK] = ctrl_new.modem_state_lock;
        // live state, which may differ from what was recorded
        md_read[msl_pkg::MD_VAL_LSB +: msl_pkg::MD_VAL_W] =
            modem_state_live;
        tx_read = 8'h00;
        tx_read[msl_pkg::TX_VAL_LSB +: msl_pkg::TX_VAL_W] =
            ctrl_new.tx_state_value;
        tx_read[msl_pkg::BIT_MD_UPD] = ctrl_new.modem_state_update;
    end

    always_comb begin
        st_nxt       = st_r;
        st_nxt.ctrl  = ctrl_new;
        st_nxt.wr_md = access & hwrite & hit_md;
        st_nxt.wr_tx = access & hwrite & hit_tx;
        // read data is captured at the address phase; unmapped reads zero
        if (access & ~hwrite) begin
            if (hit_md) begin
                st_nxt.rdata = {24'h000000, md_read};
            end else if (hit_tx) begin
                st_nxt.rdata = {24'h000000, tx_read};
            end else begin
                st_nxt.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.ctrl.tx_state_lock      <= msl_pkg::RST_TX_LOCK;
            st_r.ctrl.modem_state_lock   <= msl_pkg::RST_MD_LOCK;
            st_r.ctrl.modem_state_update <= msl_pkg::RST_MD_UPD;
            st_r.ctrl.modem_state_rec    <= msl_pkg::RST_MD_REC;
            st_r.ctrl.tx_state_value     <= msl_pkg::RST_TX_VAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = msl_pkg::HRESP_OKAY;
    assign hrdata    = st_r.rdata;

    msl_force u_force (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ctrl    (st_r.ctrl),
        .force_cmd (modem_force)
    );
endmodule // msl_top
`default_nettype wire

// ==== msl_pkg.sv ====
// package: register map, field layout, reset values and carrier types
package msl_pkg;
    // printed offsets are register indices; byte address is four times this
    localparam logic [15:0] IDX_MODEM_CTRL = 16'h2271;
    localparam logic [15:0] IDX_TX_CTRL    = 16'h2272;
    localparam logic [1:0]  ADDR_PAD       = 2'h0;
    localparam logic [13:0] ADDR_TOP       = 14'h0000;

    // modem_state_control layout
    localparam int BIT_TX_LOCK = 7;
    localparam int BIT_MD_LOCK = 4;
    localparam int MD_VAL_LSB  = 0;
    localparam int MD_VAL_W    = 4;

    // tx_state_control layout
    localparam int TX_VAL_LSB  = 0;
    localparam int TX_VAL_W    = 3;
    localparam int BIT_MD_UPD  = 4;

    // reset values
    localparam logic                RST_TX_LOCK = 1'b1;
    localparam logic                RST_MD_LOCK = 1'b1;
    localparam logic                RST_MD_UPD  = 1'b1;
    localparam logic [MD_VAL_W-1:0] RST_MD_REC  = 4'h0;
    localparam logic [TX_VAL_W-1:0] RST_TX_VAL  = 3'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

    // modem state codes
    typedef enum logic [3:0] {
        STATE_IDLE      = 4'h0,
        STATE_DC_CAL    = 4'h1,
        STATE_WAIT_ON   = 4'h2,
        STATE_WAIT_LOCK = 4'h3,
        STATE_READY     = 4'h4,
        STATE_TX_CAL    = 4'h5,
        STATE_TX_PACKET = 4'h6,
        STATE_RX_CAL    = 4'h7,
        STATE_RX_ON     = 4'h8,
        STATE_RX_PACKET = 4'h9
    } msl_mstate_t;

    // software-side control handed to the force logic
    typedef struct packed {
        logic                tx_state_lock;
        logic                modem_state_lock;
        logic                modem_state_update;
        logic [MD_VAL_W-1:0] modem_state_rec;
        logic [TX_VAL_W-1:0] tx_state_value;
    } msl_ctrl_t;

    // force commands toward the modem state machine
    typedef struct packed {
        logic                md_force;
        logic [MD_VAL_W-1:0] md_state;
        logic                tx_force;
        logic [TX_VAL_W-1:0] tx_state;
    } msl_force_t;

    // bus slave state
    typedef struct packed {
        msl_ctrl_t   ctrl;
        logic        wr_md;
        logic        wr_tx;
        logic [31:0] rdata;
    } msl_regs_t;
endpackage

// ==== msl_force.sv ====
// force logic: turns lock and update bits into registered force commands
`timescale 1ns/10ps
`default_nettype none
module msl_force (
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // from register bank
    input  wire msl_pkg::msl_ctrl_t ctrl,
    // to modem state machine
    output var  msl_pkg::msl_force_t force_cmd
);
    msl_pkg::msl_force_t st_r;
    msl_pkg::msl_force_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // a cleared lock or update bit drives the recorded state in
        st_nxt.md_force = ~ctrl.modem_state_lock |
                          ~ctrl.modem_state_update;
        st_nxt.md_state = ctrl.modem_state_rec;
        st_nxt.tx_force = ~ctrl.tx_state_lock;
        st_nxt.tx_state = ctrl.tx_state_value;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign force_cmd = st_r;
endmodule // msl_force
`default_nettype wire

// ==== msl_chk_assertions.sv ====
// checker: bus and force-link properties of the lock register bank
`timescale 1ns/10ps
`default_nettype none
module msl_chk (
    // clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // bus
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic [31:0]          hwdata,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // modem side
    input wire msl_pkg::msl_mstate_t modem_state_live,
    input wire msl_pkg::msl_force_t  modem_force
);
    localparam logic [31:0] A_MD = {msl_pkg::ADDR_TOP,
        msl_pkg::IDX_MODEM_CTRL, msl_pkg::ADDR_PAD};
    localparam logic [31:0] A_TX = {msl_pkg::ADDR_TOP,
        msl_pkg::IDX_TX_CTRL, msl_pkg::ADDR_PAD};
    logic go;
    logic wm_r, wt_r, rm_r, ru_r;
    // data-phase markers for md write, tx write, md read and unmapped read
    assign go = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wm_r, wt_r, rm_r, ru_r} <= 4'h0;
        end else begin
            wm_r <= go && hwrite && haddr == A_MD;
            wt_r <= go && hwrite && haddr == A_TX;
            rm_r <= go && !hwrite && haddr == A_MD;
            ru_r <= go && !hwrite && haddr != A_MD && haddr != A_TX;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus stall or error");
    property p_unm; ru_r |-> hrdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read nonzero");
    // register lands at the end of the data phase, force one edge later
    property p_txf;
        wm_r |-> ##2 modem_force.tx_force == !$past(hwdata[7], 2);
    endproperty
    a_txf: assert property (p_txf) else $error("tx force wrong");
    property p_tx;
        wt_r |-> ##2 modem_force.tx_state == $past(hwdata[2:0], 2);
    endproperty
    a_tx: assert property (p_tx) else $error("tx state wrong");
    property p_mdf;
        wm_r && !hwdata[4] |-> ##2 modem_force.md_force;
    endproperty
    a_mdf: assert property (p_mdf) else $error("md force missing");
    // a write still in flight may move the force on the following edge
    property p_hold;
        !wm_r && !wt_r && !$past(wm_r) && !$past(wt_r)
            |=> $stable(modem_force);
    endproperty
    a_hold: assert property (p_hold) else $error("force moved");
    property p_rec;
        wm_r |-> ##2 modem_force.md_state == $past(hwdata[3:0], 2);
    endproperty
    a_rec: assert property (p_rec) else $error("recorded wrong");
    property p_upd;
        wt_r && !hwdata[4] |-> ##2 modem_force.md_force;
    endproperty
    a_upd: assert property (p_upd) else $error("update no force");
    property p_live;
        rm_r |-> hrdata[3:0] == $past(modem_state_live)
            && hrdata[31:8] == 24'h0 && hrdata[6:5] == 2'h0;
    endproperty
    a_live: assert property (p_live)
        else $error("live read wrong");
endmodule // msl_chk
`default_nettype wire

// ==== msl_top_tb.sv ====
// testbench: register access and force outputs of the lock register bank
`timescale 1ns/10ps
`default_nettype none
module msl_top_tb;
    localparam logic [31:0] A_MD = {msl_pkg::ADDR_TOP,
        msl_pkg::IDX_MODEM_CTRL, msl_pkg::ADDR_PAD};
    localparam logic [31:0] A_TX = {msl_pkg::ADDR_TOP,
        msl_pkg::IDX_TX_CTRL, msl_pkg::ADDR_PAD};
    logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [31:0]          haddr, hwdata, hrdata;
    msl_pkg::msl_mstate_t live;
    msl_pkg::msl_force_t  frc;
    int                   bad_count, num_checks;
    logic [31:0] wa [7] = '{A_MD, A_MD, A_TX, A_MD, A_MD, A_TX, A_TX};
    logic [7:0]  wd [7] = '{8'h99, 8'h83, 8'h15, 8'h03, 8'h97, 8'h05, 8'h10};
    logic [8:0]  wf [7] = '{9'h090, 9'h130, 9'h135, 9'h13d, 9'h075, 9'h175,
                            9'h070};
    msl_top msl_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .modem_state_live(live), .modem_force(frc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // no limit of its own: a wait that never sees hreadyout high ends only at the watchdog
    task automatic wait_rdy;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask
    // address phase held until ready, then data phase held until ready
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(hrdata, exp);
    endtask
    // force lags the register by one cycle; sample it mid-cycle
    task automatic fchk(input logic [8:0] exp);
        @(posedge hclk);
        @(negedge hclk);
        chk({23'h0, frc}, {23'h0, exp});
        @(posedge hclk);
    endtask
    task automatic test_done;
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        #20000;
        bad_count++;
        test_done();
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        live = msl_pkg::STATE_READY;
        hresetn = 1'b0;
        bad_count = 0;
        num_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk({23'h0, frc}, 32'h0);
        rd(A_MD, 32'h94);
        rd(A_TX, 32'h10);
        live <= msl_pkg::STATE_IDLE;
        for (int i = 0; i < 7; i++) begin
            xfer(wa[i], 1'b1, {24'h0, wd[i]});
            fchk(wf[i]);
        end
        xfer(A_MD, 1'b1, 32'h66);
        rd(A_MD, 32'h00);
        fchk(9'h168);
        xfer(A_TX + 32'h4, 1'b1, 32'hffffffff);
        rd(A_TX + 32'h4, 32'h0);
        rd(A_TX, 32'h10);
        xfer(A_MD, 1'b1, 32'h90);
        for (int i = 0; i < 10; i++) begin
            live <= msl_pkg::msl_mstate_t'(i);
            rd(A_MD, 32'h90 | i);
        end
        // lock both, then reset in mid-run: locks must come back released
        xfer(A_MD, 1'b1, 32'h03);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk({23'h0, frc}, 32'h0);
        rd(A_MD, 32'h99);
        rd(A_TX, 32'h10);
        fchk(9'h000);
        test_done();
    end
endmodule // msl_top_tb
bind msl_top msl_chk msl_chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .modem_state_live, .modem_force);
`default_nettype wire
